// ===== logic/rpc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - release buffer protection on read end/leave listen
// - pll entry calibrates then sleeps
// - rx/tx, channel, calibration wake pll temporarily
// - smart receive in listen, aack, aret states
// - cca or ed scan suspends smart/desense
// - desensitize in auto_ack_receive_state rx, aret states
// - level 0x08 desense flags unresolved rssi band
// - ack power reduced only on strong good frame
// - ack power floor -17dBm, ceiling programmed
// - power readback shows last used power
// - repeated sequence number means no reduction
// - aret retries restart at maximum power
// - pan mismatch aborts and relistens at once
// - pan match, filter fail: save rest/ack
// - promiscuous mode disables pan match
// - protected buffer in rx states saves power
// - initial aret backoff saves power
// - ack wait periods save power
// - control field 0 minimum, 3 maximum
module rpc_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_power_reduction_control,
  input wire logic i_promiscuous_receive_bit,
  input wire logic i_short_ack_time_bit,
  input wire logic i_reserved_frame_filter_bit,
  input wire logic [3:0] i_detection_threshold_level,
  input wire logic [3:0] i_transmit_power_field,
  input wire rpc_pkg::rpc_trx_state_e i_trx_state,
  input wire logic i_safe_mode,
  input wire logic i_frame_stored,
  input wire logic i_fb_read_active,
  input wire logic i_sel_rise,
  input wire logic i_chan_change,
  input wire logic i_cal_request,
  input wire logic i_pll_op_done,
  input wire logic i_cca_ed_active,
  input wire logic i_frame_ok,
  input wire logic [7:0] i_frame_ed,
  input wire logic [7:0] i_frame_lqi,
  input wire logic [7:0] i_frame_seq,
  input wire logic i_ack_tx_start,
  input wire logic i_tx_start,
  input wire logic i_tx_fail,
  input wire logic i_tx_done,
  input wire logic i_backoff_active,
  input wire logic i_ack_wait,
  input wire logic i_ack_pending,
  input wire logic i_pan_checked,
  input wire logic i_pan_match,
  input wire logic i_addr_match,
  input wire logic i_ack_requested,
  input wire logic i_frame_end,
  output logic o_fb_protect,
  output logic o_pll_calibrate,
  output logic o_pll_saving,
  output logic o_smart_receive,
  output logic [1:0] o_smart_receive_control,
  output logic o_desensitize,
  output logic o_rssi_unresolved,
  output logic o_rx_abort,
  output logic o_power_save,
  output logic [3:0] o_tx_power,
  output logic [3:0] o_transmit_power_field
);
  import rpc_pkg::*;

  logic [7:0] cfg;
  assign cfg = i_power_reduction_control;
  wire smart_en = cfg[RPC_SRX_EN_BIT];
  wire des_en = cfg[RPC_DES_EN_BIT];
  wire pll_en = cfg[RPC_PLL_EN_BIT];
  wire atx_en = cfg[RPC_ATX_EN_BIT];
  wire pan_en = cfg[RPC_PAN_EN_BIT] && !i_promiscuous_receive_bit;

  function automatic logic is_listen(input rpc_trx_state_e s);
    is_listen = (s == RPC_ST_RX_ON) || (s == RPC_ST_AACK_ON);
  endfunction

  wire st_listen = is_listen(i_trx_state);
  wire st_rx = (i_trx_state == RPC_ST_RX_ON) || (i_trx_state == RPC_ST_BUSY_RX);
  wire st_aack = (i_trx_state == RPC_ST_AACK_ON) || (i_trx_state == RPC_ST_AACK_RX);
  wire st_aret = (i_trx_state == RPC_ST_ARET);
  wire st_pll = (i_trx_state == RPC_ST_PLL_ON) || (i_trx_state == RPC_ST_ARET_ON);

  // state change tracking
  rpc_trx_state_e prev_state;
  wire listen_left = is_listen(prev_state) && (i_trx_state != prev_state);
  wire pll_entry = st_pll && (i_trx_state != prev_state);

  // frame buffer protection
  logic fb_protect;
  wire fb_release = (i_sel_rise && i_fb_read_active) || listen_left;
  // a frame stored in the release cycle stays protected, else it could be overwritten
  wire fb_set = i_safe_mode && st_listen && i_frame_stored;
  wire next_fb_protect = fb_set ? 1'b1 : (fb_release ? 1'b0 : fb_protect);

  // pll saving sequencer
  typedef enum logic [1:0] {RPC_PLL_AWAKE, RPC_PLL_CAL, RPC_PLL_SLEEP, RPC_PLL_WAKE} rpc_pll_e;
  rpc_pll_e pll_st;
  rpc_pll_e next_pll_st;
  wire wake_req = i_chan_change || i_cal_request || !st_pll;
  always_comb begin
    next_pll_st = pll_st;
    case (pll_st)
      RPC_PLL_AWAKE: begin
        if (pll_en && pll_entry) begin
          next_pll_st = RPC_PLL_CAL;
        end
      end
      RPC_PLL_CAL: begin
        if (i_pll_op_done) begin
          next_pll_st = RPC_PLL_SLEEP;
        end
      end
      RPC_PLL_SLEEP: begin
        if (!pll_en) begin
          next_pll_st = RPC_PLL_AWAKE;
        end else if (wake_req) begin
          next_pll_st = RPC_PLL_WAKE;
        end
      end
      RPC_PLL_WAKE: begin
        if (!pll_en) begin
          next_pll_st = RPC_PLL_AWAKE;
        end else if (i_pll_op_done && st_pll) begin
          next_pll_st = RPC_PLL_SLEEP;
        end
      end
      default: next_pll_st = RPC_PLL_AWAKE;
    endcase
  end

  // smart receive and desensitizing
  wire smart_states = st_listen || st_aret;
  wire des_states = st_rx || (i_trx_state == RPC_ST_AACK_RX) || st_aret;
  wire next_smart = smart_en && smart_states && !i_cca_ed_active;
  wire next_des = des_en && des_states && !i_cca_ed_active;
  // 0x08 desense level cannot resolve -83..-70 dBm
  wire next_unres = next_des && (i_detection_threshold_level == RPC_PDT_SPECIAL);
  // reserved codes 1,2 treated as minimum saving
  wire [1:0] next_srx_ctrl = (cfg[RPC_SRX_CTRL_MSB:RPC_SRX_CTRL_LSB] == RPC_SRX_MAX) ?
                             RPC_SRX_MAX : RPC_SRX_MIN;

  // pan match recognition
  logic pan_save;
  wire pan_active = pan_en && (i_trx_state == RPC_ST_AACK_RX) && i_pan_checked;
  wire next_abort = pan_active && !i_pan_match;
  wire pan_fail_save = pan_active && i_pan_match && !i_addr_match;
  logic pan_ack_hold;
  wire next_pan_save = pan_fail_save || (pan_save && !i_frame_end) ||
                       (pan_save && i_frame_end && pan_ack_hold);

  // automatic ack power
  rpc_ack_if ack_bus ();
  assign ack_bus.enable = atx_en && st_aack;
  assign ack_bus.frame_ok = i_frame_ok && st_aack;
  assign ack_bus.ed = i_frame_ed;
  assign ack_bus.lqi = i_frame_lqi;
  assign ack_bus.seq = i_frame_seq;
  assign ack_bus.limit = i_transmit_power_field;
  rpc_ack_power u_ack_power (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .ack(ack_bus)
  );

  // retry power in aret
  logic retry_max;
  wire next_retry_max = (atx_en && st_aret) ? (i_tx_fail ? 1'b1 : retry_max) : 1'b0;
  wire [3:0] aret_power = retry_max ? RPC_PWR_MAX : i_transmit_power_field;
  logic [3:0] tx_power;
  wire [3:0] next_tx_power = i_ack_tx_start ? ack_bus.power :
                             (i_tx_start ? (st_aret ? aret_power : i_transmit_power_field)
                                         : tx_power);
  logic [3:0] used_power;
  wire [3:0] next_used = (i_tx_done || i_ack_tx_start) ? next_tx_power : used_power;

  // automatic power save
  wire save_fb = next_fb_protect && (st_rx || st_aack);
  wire save_bo = st_aret && i_backoff_active;
  wire save_ack = (st_aret && i_ack_wait) || (st_aack && i_ack_pending);
  wire next_save = save_fb || save_bo || save_ack || next_pan_save;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      prev_state <= RPC_ST_OFF;
      fb_protect <= 1'b0;
      pll_st <= RPC_PLL_AWAKE;
      pan_save <= 1'b0;
      pan_ack_hold <= 1'b0;
      retry_max <= 1'b0;
      tx_power <= RPC_PWR_MAX;
      used_power <= RPC_PWR_MAX;
    end else begin
      prev_state <= i_trx_state;
      fb_protect <= next_fb_protect;
      pll_st <= next_pll_st;
      pan_save <= next_pan_save && !(pan_save && i_frame_end && !pan_ack_hold);
      pan_ack_hold <= pan_fail_save ? i_ack_requested : (i_frame_end ? 1'b0 : pan_ack_hold);
      retry_max <= next_retry_max;
      tx_power <= next_tx_power;
      used_power <= next_used;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_smart_receive <= 1'b0;
      o_smart_receive_control <= RPC_SRX_MIN;
      o_desensitize <= 1'b0;
      o_rssi_unresolved <= 1'b0;
      o_rx_abort <= 1'b0;
      o_power_save <= 1'b0;
    end else begin
      o_smart_receive <= next_smart;
      o_smart_receive_control <= next_srx_ctrl;
      o_desensitize <= next_des;
      o_rssi_unresolved <= next_unres;
      o_rx_abort <= next_abort;
      o_power_save <= next_save;
    end
  end

  assign o_fb_protect = fb_protect;
  assign o_pll_calibrate = (pll_st == RPC_PLL_CAL);
  assign o_pll_saving = (pll_st == RPC_PLL_SLEEP);
  assign o_tx_power = tx_power;
  assign o_transmit_power_field = used_power;

  sequence s_read_end;
    i_sel_rise && i_fb_read_active;
  endsequence
  property p_fb_release;
    @(posedge i_ref_clk) disable iff (!i_rst_b) s_read_end && !fb_set |=> !o_fb_protect;
  endproperty
  a_fb_release: assert property (p_fb_release) else $error("protect not released");
  property p_pll_cal;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_pll_calibrate && i_pll_op_done && pll_en |=> o_pll_saving;
  endproperty
  a_pll_cal: assert property (p_pll_cal) else $error("pll did not sleep");
  property p_pll_wake;
    @(posedge i_ref_clk) disable iff (!i_rst_b) o_pll_saving && i_chan_change |=> !o_pll_saving;
  endproperty
  a_pll_wake: assert property (p_pll_wake) else $error("pll not woken");
  property p_cca;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_cca_ed_active |=> !o_smart_receive && !o_desensitize;
  endproperty
  a_cca: assert property (p_cca) else $error("scheme active in scan");
  property p_smart;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      smart_en && st_listen && !i_cca_ed_active |=> o_smart_receive;
  endproperty
  a_smart: assert property (p_smart) else $error("smart receive off");
  property p_off;
    @(posedge i_ref_clk) disable iff (!i_rst_b) !des_en |=> !o_desensitize;
  endproperty
  a_off: assert property (p_off) else $error("desense while disabled");
  property p_pan;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_promiscuous_receive_bit |=> !o_rx_abort;
  endproperty
  a_pan: assert property (p_pan) else $error("pan abort in promiscuous");
  property p_retry;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      atx_en && st_aret && i_tx_fail ##1 st_aret && i_tx_start |=> o_tx_power == RPC_PWR_MAX;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not at max");
  property p_backoff;
    @(posedge i_ref_clk) disable iff (!i_rst_b) st_aret && i_backoff_active |=> o_power_save;
  endproperty
  a_backoff: assert property (p_backoff) else $error("no save in backoff");
  property p_fb_leave;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      listen_left && !fb_set |=> !o_fb_protect;
  endproperty
  a_fb_leave: assert property (p_fb_leave) else $error("protect kept on leave");
  property p_fb_save;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      fb_set && (st_rx || st_aack) |=> o_power_save;
  endproperty
  a_fb_save: assert property (p_fb_save) else $error("no save while protected");
  property p_pll_entry;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (pll_st == RPC_PLL_AWAKE) && pll_en && pll_entry |=> o_pll_calibrate;
  endproperty
  a_pll_entry: assert property (p_pll_entry) else $error("no pll calibration");
  property p_pll_off;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_pll_saving && !pll_en |=> !o_pll_saving;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll saving while disabled");
  property p_des;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      des_en && des_states && !i_cca_ed_active |=> o_desensitize;
  endproperty
  a_des: assert property (p_des) else $error("desense off");
  property p_unres;
    @(posedge i_ref_clk) disable iff (!i_rst_b) des_en && des_states && !i_cca_ed_active &&
      (i_detection_threshold_level == RPC_PDT_SPECIAL) |=> o_rssi_unresolved;
  endproperty
  a_unres: assert property (p_unres) else $error("unresolved band not flagged");
  property p_srx_ctrl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (cfg[RPC_SRX_CTRL_MSB:RPC_SRX_CTRL_LSB] == RPC_SRX_MAX) |=> o_smart_receive_control == RPC_SRX_MAX;
  endproperty
  a_srx_ctrl: assert property (p_srx_ctrl) else $error("smart control not max");
  property p_smart_off;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !smart_en |=> !o_smart_receive;
  endproperty
  a_smart_off: assert property (p_smart_off) else $error("smart while disabled");
  property p_abort;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      pan_active && !i_pan_match |=> o_rx_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on pan mismatch");
  property p_pan_save;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      pan_fail_save |=> o_power_save;
  endproperty
  a_pan_save: assert property (p_pan_save) else $error("no save on filter fail");
  property p_ack_wait;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_aret && i_ack_wait) || (st_aack && i_ack_pending) |=> o_power_save;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("no save in ack wait");
  property p_readback;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_ack_tx_start |=> o_transmit_power_field == o_tx_power;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not ack power");
  property p_retry_first;
    @(posedge i_ref_clk) disable iff (!i_rst_b) atx_en && st_aret && i_tx_start && !retry_max &&
      !i_ack_tx_start |=> o_tx_power == $past(i_transmit_power_field);
  endproperty
  a_retry_first: assert property (p_retry_first) else $error("first try not programmed");
endmodule

// ===== logic/rpc_pkg.sv
package rpc_pkg;
  localparam logic [7:0] RPC_CTRL_RESET = 8'hC1;
  localparam int RPC_SRX_CTRL_MSB = 7;
  localparam int RPC_SRX_CTRL_LSB = 6;
  localparam int RPC_SRX_EN_BIT = 5;
  localparam int RPC_DES_EN_BIT = 4;
  localparam int RPC_PLL_EN_BIT = 3;
  localparam int RPC_ATX_EN_BIT = 2;
  localparam int RPC_PAN_EN_BIT = 1;
  localparam logic [1:0] RPC_SRX_MIN = 2'h0;
  localparam logic [1:0] RPC_SRX_MAX = 2'h3;
  localparam logic [3:0] RPC_PDT_SPECIAL = 4'h8;
  // power codes: lower code means more output power
  localparam logic [3:0] RPC_PWR_MAX = 4'h0;
  localparam logic [3:0] RPC_PWR_MIN = 4'hF;
  // ed in dBm above floor -100; lqi raw
  localparam logic [7:0] RPC_ED_REDUCE = 8'h17;
  localparam logic [7:0] RPC_ED_FLOOR = 8'h37;
  localparam logic [7:0] RPC_LQI_THR = 8'hE0;
  typedef enum logic [3:0] {
    RPC_ST_OFF, RPC_ST_PLL_ON, RPC_ST_RX_ON, RPC_ST_BUSY_RX, RPC_ST_AACK_ON,
    RPC_ST_AACK_RX, RPC_ST_ARET_ON, RPC_ST_ARET, RPC_ST_BUSY_TX
  } rpc_trx_state_e;
endpackage

// ===== logic/rpc_ack_if.sv
`timescale 1ns/1ps
interface rpc_ack_if;
  import rpc_pkg::*;
  logic enable;
  logic frame_ok;
  logic [7:0] ed;
  logic [7:0] lqi;
  logic [7:0] seq;
  logic [3:0] limit;
  logic [3:0] power;
  modport ctrl (output enable, frame_ok, ed, lqi, seq, limit, input power);
  modport calc (input enable, frame_ok, ed, lqi, seq, limit, output power);
endinterface

// ===== logic/rpc_ack_power.sv
`timescale 1ns/1ps
module rpc_ack_power (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  rpc_ack_if.calc ack
);
  import rpc_pkg::*;
  logic [7:0] last_seq;
  logic seq_valid;
  logic [3:0] power;
  wire same_seq = seq_valid && (ack.seq == last_seq);
  wire good = ack.enable && !same_seq && (ack.lqi > RPC_LQI_THR);
  wire floor_hit = good && (ack.ed > RPC_ED_FLOOR);
  wire reduce = good && (ack.ed > RPC_ED_REDUCE);
  // linear step between thresholds, never stronger than the limit
  wire [7:0] span = ack.ed - RPC_ED_REDUCE;
  wire [3:0] step = span[5:2];
  wire [3:0] raw = (step > ack.limit) ? step : ack.limit;
  wire [3:0] next_power = floor_hit ? RPC_PWR_MIN : (reduce ? raw : ack.limit);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      power <= RPC_PWR_MAX;
      last_seq <= 8'h00;
      seq_valid <= 1'b0;
    end else if (ack.frame_ok) begin
      power <= next_power;
      last_seq <= ack.seq;
      seq_valid <= 1'b1;
    end
  end
  assign ack.power = power;
endmodule

// ===== tb/rpc_host_model.sv
`timescale 1ns/1ps
module rpc_host_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_want,
  output logic [7:0] o_power_reduction_control
);
  // a write lands one edge later, like a finished register access
  always_ff @(posedge i_ref_clk) begin
    o_power_reduction_control <= i_want | 8'h01;
  end
endmodule

// ===== tb/reduced_power_radio_control_bench.sv
`timescale 1ns/1ps
module reduced_power_radio_control_bench;
  import rpc_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] want = 8'hC1;
  logic [7:0] cfg, ed = 8'h00, lqi = 8'h00, seq = 8'h00;
  logic prom = 0, safe = 0, fst = 0, fbrd = 0, selr = 0, chan = 0, calr = 0, opd = 0, cca = 0;
  logic fok = 0, ackst = 0, txs = 0, txf = 0, boff = 0, ackw = 0, ackp = 0, txd = 0, fend = 0;
  logic panc = 0, panm = 0, addrm = 0, ackreq = 0;
  logic [3:0] pdt = 4'h0, pwr = 4'h0, txp, txrb;
  logic fbp, pcal, psav, srx, des, unres, abrt, psave;
  logic [1:0] sctl;
  logic [23:0] cs [6] = '{24'h40F001, 24'h40F001, 24'h17F002, 24'h40E003, 24'h50FF04,
    24'h2BF005};
  rpc_trx_state_e st = RPC_ST_OFF;
  rpc_trx_state_e sts [7] = '{RPC_ST_OFF, RPC_ST_PLL_ON, RPC_ST_RX_ON, RPC_ST_AACK_ON,
    RPC_ST_AACK_RX, RPC_ST_ARET_ON, RPC_ST_ARET};
  int n_errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  rpc_host_model host_u (.i_ref_clk(clk), .i_want(want), .o_power_reduction_control(cfg));
  rpc_ctrl dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_power_reduction_control(cfg),
    .i_promiscuous_receive_bit(prom), .i_short_ack_time_bit(1'h0),
    .i_reserved_frame_filter_bit(1'h0), .i_detection_threshold_level(pdt),
    .i_transmit_power_field(pwr), .i_trx_state(st), .i_safe_mode(safe),
    .i_frame_stored(fst), .i_fb_read_active(fbrd), .i_sel_rise(selr), .i_chan_change(chan),
    .i_cal_request(calr), .i_pll_op_done(opd), .i_cca_ed_active(cca), .i_frame_ok(fok),
    .i_frame_ed(ed), .i_frame_lqi(lqi), .i_frame_seq(seq), .i_ack_tx_start(ackst),
    .i_tx_start(txs), .i_tx_fail(txf), .i_tx_done(txd), .i_backoff_active(boff),
    .i_ack_wait(ackw), .i_ack_pending(ackp), .i_pan_checked(panc), .i_pan_match(panm),
    .i_addr_match(addrm), .i_ack_requested(ackreq), .i_frame_end(fend),
    .o_fb_protect(fbp), .o_pll_calibrate(pcal), .o_pll_saving(psav), .o_smart_receive(srx),
    .o_smart_receive_control(sctl), .o_desensitize(des), .o_rssi_unresolved(unres),
    .o_rx_abort(abrt), .o_power_save(psave), .o_tx_power(txp), .o_transmit_power_field(txrb));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic setc(input logic [7:0] v);
    want = v;
    step(2);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("counts: checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // only unambiguous states are compared; the others are skipped by the caller
  function automatic logic [3:0] e_srx(logic [7:0] c, rpc_trx_state_e s, logic a);
    return 4'(c[RPC_SRX_EN_BIT] && !a && (s == RPC_ST_RX_ON || s == RPC_ST_AACK_ON
      || s == RPC_ST_ARET));
  endfunction
  function automatic logic [3:0] e_des(logic [7:0] c, rpc_trx_state_e s, logic a);
    return 4'(c[RPC_DES_EN_BIT] && !a && (s == RPC_ST_RX_ON || s == RPC_ST_AACK_RX
      || s == RPC_ST_ARET));
  endfunction
  // reduction steps one code per 4 dB above the reduce threshold, never above the limit
  function automatic logic [3:0] e_pwr(logic [7:0] e, logic [7:0] l, logic [3:0] f, logic r);
    logic [7:0] d;
    d = (e - RPC_ED_REDUCE) >> 2;
    if (r || l <= RPC_LQI_THR || e <= RPC_ED_REDUCE)
      return f;
    if (e > RPC_ED_FLOOR)
      return RPC_PWR_MIN;
    return (d[3:0] > f) ? d[3:0] : f;
  endfunction
  initial begin
    void'($urandom(44027));
    step(20);
    chk(4'(psav | srx | des | psave | fbp), 4'h0);
    rst_b = 1'h1;
    want = 8'h01;
    safe = 1'h1;
    st = RPC_ST_RX_ON;
    step(2);
    pulse(fst);
    chk(4'(fbp), 4'h1);
    chk(4'(psave), 4'h1);
    fbrd = 1'h1;
    pulse(selr);
    fbrd = 1'h0;
    chk(4'(fbp), 4'h0);
    pulse(fst);
    chk(4'(fbp), 4'h1);
    st = RPC_ST_PLL_ON;
    step(2);
    chk(4'(fbp), 4'h0);
    safe = 1'h0;
    tdone("buffer protection");
    st = RPC_ST_OFF;
    setc(8'h09);
    st = RPC_ST_PLL_ON;
    step(1);
    chk(4'(pcal), 4'h1);
    pulse(opd);
    chk(4'(psav), 4'h1);
    pulse(chan);
    chk(4'(psav), 4'h0);
    pulse(opd);
    chk(4'(psav), 4'h1);
    pulse(calr);
    chk(4'(psav), 4'h0);
    pulse(opd);
    chk(4'(psav), 4'h1);
    st = RPC_ST_OFF;
    setc(8'h01);
    st = RPC_ST_PLL_ON;
    step(2);
    chk(4'(psav), 4'h0);
    tdone("pll saving");
    for (int k = 0; k < 40; k++) begin
      want = (k == 0) ? 8'hFF : (k == 1) ? 8'hC1 : 8'($urandom);
      st = sts[$urandom_range(6)];
      cca = 1'($urandom);
      pdt = k[0] ? RPC_PDT_SPECIAL : 4'($urandom);
      step(3);
      if (st != RPC_ST_AACK_RX) begin
        chk(4'(srx), e_srx(cfg, st, cca));
        if (srx === 1'h1)
          chk(4'(sctl), (cfg[7:6] == RPC_SRX_MAX) ? 4'h3 : 4'h0);
      end
      if (st != RPC_ST_AACK_ON) begin
        chk(4'(des), e_des(cfg, st, cca));
        chk(4'(unres), 4'(e_des(cfg, st, cca) != 0 && pdt == RPC_PDT_SPECIAL));
      end
    end
    tdone("random schemes");
    setc(8'h01);
    st = RPC_ST_ARET;
    boff = 1'h1;
    step(2);
    chk(4'(psave), 4'h1);
    boff = 1'h0;
    ackw = 1'h1;
    step(2);
    chk(4'(psave), 4'h1);
    ackw = 1'h0;
    st = RPC_ST_AACK_RX;
    ackp = 1'h1;
    step(2);
    chk(4'(psave), 4'h1);
    ackp = 1'h0;
    st = RPC_ST_RX_ON;
    step(2);
    chk(4'(psave), 4'h0);
    tdone("auto save");
    setc(8'h05);
    st = RPC_ST_AACK_RX;
    pwr = 4'h3;
    for (int k = 0; k < 6; k++) begin
      {ed, lqi, seq} = cs[k];
      pulse(fok);
      pulse(ackst);
      step(1);
      chk(txp, e_pwr(ed, lqi, pwr, k == 1));
      chk(txrb, e_pwr(ed, lqi, pwr, k == 1));
    end
    st = RPC_ST_ARET;
    pwr = 4'h5;
    step(1);
    pulse(txs);
    step(1);
    chk(txp, 4'h5);
    pulse(txd);
    chk(txrb, 4'h5);
    pulse(txf);
    pulse(txs);
    pulse(txd);
    chk(txp, RPC_PWR_MAX);
    chk(txrb, RPC_PWR_MAX);
    tdone("tx power");
    setc(8'h03);
    st = RPC_ST_AACK_RX;
    pulse(panc);
    chk(4'(abrt), 4'h1);
    step(1);
    chk(4'(abrt), 4'h0);
    prom = 1'h1;
    step(1);
    pulse(panc);
    chk(4'(abrt), 4'h0);
    prom = 1'h0;
    panm = 1'h1;
    ackreq = 1'h1;
    pulse(panc);
    step(1);
    chk(4'(psave), 4'h1);
    pulse(fend);
    chk(4'(psave), 4'h1);
    pulse(fend);
    chk(4'(psave), 4'h0);
    tdone("pan match");
    conclude();
  end
endmodule
